//--- hw/swseq_top.sv
// Sweep sequencer: AHB-Lite registers, trigger selection and sweep state machine
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "swseq_defines.svh"

module swseq_top
	import swseq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic trigIn,
	input wire logic cycleEdge,
	input wire logic halfCycleEdge,
	output swseq_gen_t gen,
	output logic sweepSyncOut,
	output logic trigAccepted,
	output logic conflict
);
	logic [1:0] rstPipe;
	logic rstN;
	swseq_state_t s;
	swseq_state_t next_s;

	logic [1:0] runSel;
	logic shuttle;
	logic extSrc;
	logic [1:0] pol;
	logic idleEn;
	logic halfUnit;
	logic syncEn;
	logic enable;
	logic isPhase;
	logic singleMode;
	logic gated;
	logic [9:0] cmdWord;
	logic [15:0] absSpan;
	logic dirUp;
	logic [32:0] errSum;
	logic [32:0] stepErr;
	logic stepNow;
	logic [31:0] elapsedInc;
	logic legEnd;
	logic [15:0] valueStep;
	logic riseEdge;
	logic fallEdge;
	logic extTrig;
	logic intTick;
	logic anyTrig;
	logic trigTake;
	logic boundary;

	// Reset released through two flops so every state flop leaves reset on the same edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rstPipe <= 2'b00;
		end
		else
		begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstN = rstPipe[1];

	assign runSel = s.ctrl[`SWSEQ_CTRL_RUN +: 2];
	assign shuttle = s.ctrl[`SWSEQ_CTRL_SHUTTLE];
	assign extSrc = s.ctrl[`SWSEQ_CTRL_EXT];
	assign pol = s.ctrl[`SWSEQ_CTRL_POL +: 2];
	assign idleEn = s.ctrl[`SWSEQ_CTRL_IDLEEN];
	assign halfUnit = s.ctrl[`SWSEQ_CTRL_HALF];
	assign syncEn = s.ctrl[`SWSEQ_CTRL_SYNCEN];
	assign enable = s.ctrl[`SWSEQ_CTRL_ENABLE];
	assign isPhase = s.ctrl[`SWSEQ_CTRL_ISPHASE];
	assign singleMode = (runSel == SWSEQ_SINGLE) || (runSel == SWSEQ_GATED);
	assign gated = (runSel == SWSEQ_GATED);

	// Commands are write-only pulses, live in the data phase of a CMD write
	assign cmdWord = (s.busWr && s.busAddr == `SWSEQ_OFF_CMD) ? hwdata[9:0] : 10'h000;

	// Stepper moves at most one count per clock, so the span may not exceed the time
	assign conflict = (s.sweepTime == 32'h0000_0000)
		|| ({16'h0000, absSpan} > s.sweepTime)
		|| (runSel == 2'h3)
		|| (singleMode && !extSrc && s.trigPeriod == 32'h0000_0000)
		|| (idleEn && s.idleLevel > `SWSEQ_IDLE_MAX);

	// Direction set by endpoint order, reversed on the return leg
	assign absSpan = (s.endVal >= s.startVal) ? s.endVal - s.startVal : s.startVal - s.endVal;
	assign dirUp = (s.endVal >= s.startVal) ^ s.backLeg;
	assign errSum = {1'b0, s.err} + {17'h0_0000, absSpan};
	assign stepErr = errSum - {1'b0, s.sweepTime};
	assign stepNow = errSum >= {1'b0, s.sweepTime};
	assign elapsedInc = s.elapsed + 32'h0000_0001;
	assign legEnd = (elapsedInc == s.sweepTime);
	assign valueStep = dirUp ? s.value + 16'h0001 : s.value - 16'h0001;

	// Pin edges taken only from the second synchroniser stage onward
	assign riseEdge = s.pinSync && !s.pinPrev;
	assign fallEdge = !s.pinSync && s.pinPrev;
	assign extTrig = extSrc && ((pol == `SWSEQ_POL_RISE && riseEdge)
		|| (pol == `SWSEQ_POL_FALL && fallEdge));
	assign anyTrig = extTrig || (!extSrc && intTick)
		|| cmdWord[`SWSEQ_CMD_MANUAL] || cmdWord[`SWSEQ_CMD_REMOTE]
		|| cmdWord[`SWSEQ_CMD_START];
	assign trigTake = anyTrig && singleMode && enable && !conflict
		&& s.phase != SWSEQ_RUN && s.phase != SWSEQ_DRAIN;
	assign boundary = cycleEdge || (halfUnit && halfCycleEdge);

	swseq_trig_timer u_timer (
		.clk(clk),
		.rstN(rstN),
		.run(enable && singleMode && !extSrc),
		.period(s.trigPeriod),
		.tick(intTick)
	);

	always_comb
	begin
		next_s = s;
		next_s.trigPulse = 1'b0;
		next_s.pinMeta = trigIn;
		next_s.pinSync = s.pinMeta;
		next_s.pinPrev = s.pinSync;

		// Data phase of a write
		if (s.busWr)
		begin
			case (s.busAddr)
				`SWSEQ_OFF_CTRL: next_s.ctrl = hwdata[10:0];
				`SWSEQ_OFF_START: next_s.startVal = hwdata[15:0];
				`SWSEQ_OFF_END: next_s.endVal = hwdata[15:0];
				`SWSEQ_OFF_TIME: next_s.sweepTime = hwdata;
				`SWSEQ_OFF_PERIOD: next_s.trigPeriod = hwdata;
				`SWSEQ_OFF_IDLE: next_s.idleLevel = hwdata[6:0];
				`SWSEQ_OFF_PHASE: next_s.phaseReg = hwdata[15:0];
				default: ;
			endcase
		end
		if (cmdWord[`SWSEQ_CMD_SWAP])
		begin
			next_s.startVal = s.endVal;
			next_s.endVal = s.startVal;
		end

		// Trigger seen flag: a new trigger beats a clear in the same cycle
		if (cmdWord[`SWSEQ_CMD_CLRTRIG])
		begin
			next_s.trigd = 1'b0;
		end
		if (trigTake)
		begin
			next_s.trigd = 1'b1;
			next_s.trigPulse = 1'b1;
		end

		if (!enable)
		begin
			next_s.phase = SWSEQ_IDLE;
			next_s.osc = 1'b0;
			next_s.stopped = 1'b0;
			next_s.value = next_s.startVal;
			next_s.backLeg = 1'b0;
			next_s.sync = 1'b1;
		end
		else if (cmdWord[`SWSEQ_CMD_STOP])
		begin
			next_s.phase = SWSEQ_IDLE;
			next_s.value = next_s.startVal;
			next_s.osc = 1'b0;
			next_s.backLeg = 1'b0;
			next_s.sync = 1'b1;
			next_s.stopped = 1'b1;
		end
		else if (cmdWord[`SWSEQ_CMD_TOSTART] || cmdWord[`SWSEQ_CMD_TOEND])
		begin
			next_s.phase = SWSEQ_FORCE;
			next_s.value = cmdWord[`SWSEQ_CMD_TOEND] ? next_s.endVal : next_s.startVal;
			next_s.osc = gated;
			next_s.backLeg = 1'b0;
			next_s.sync = 1'b1;
			next_s.stopped = 1'b1;
		end
		else if (trigTake)
		begin
			next_s.phase = SWSEQ_RUN;
			next_s.elapsed = 32'h0000_0000;
			next_s.err = 32'h0000_0000;
			next_s.osc = gated;
			next_s.sync = 1'b0;
			if (s.phase != SWSEQ_WAIT)
			begin
				next_s.value = next_s.startVal;
				next_s.backLeg = 1'b0;
			end
		end
		else if (!singleMode && !conflict
			&& (cmdWord[`SWSEQ_CMD_START] || (s.phase == SWSEQ_IDLE && !s.stopped)))
		begin
			next_s.phase = SWSEQ_RUN;
			next_s.stopped = 1'b0;
			next_s.value = next_s.startVal;
			next_s.elapsed = 32'h0000_0000;
			next_s.err = 32'h0000_0000;
			next_s.backLeg = 1'b0;
			next_s.sync = 1'b0;
		end
		else
		begin
			unique case (s.phase)
				SWSEQ_RUN:
				begin
					if (cmdWord[`SWSEQ_CMD_HOLD])
					begin
						next_s.phase = SWSEQ_HOLD;
					end
					else
					begin
						next_s.elapsed = elapsedInc;
						if (stepNow)
						begin
							next_s.value = valueStep;
							next_s.err = stepErr[31:0];
						end
						else
						begin
							next_s.err = errSum[31:0];
						end
						// Sync rises halfway through the forward leg so each start shows a falling edge
						if (!s.backLeg && elapsedInc == {1'b0, s.sweepTime[31:1]})
						begin
							next_s.sync = 1'b1;
						end
						if (legEnd)
						begin
							next_s.elapsed = 32'h0000_0000;
							next_s.err = 32'h0000_0000;
							next_s.sync = 1'b1;
							if (gated)
							begin
								next_s.phase = SWSEQ_DRAIN;
							end
							else if (shuttle && !s.backLeg)
							begin
								next_s.backLeg = 1'b1;
								if (singleMode)
								begin
									next_s.phase = SWSEQ_WAIT;
								end
							end
							else if (!singleMode)
							begin
								next_s.value = next_s.startVal;
								next_s.backLeg = 1'b0;
								next_s.sync = 1'b0;
							end
							else
							begin
								next_s.phase = SWSEQ_IDLE;
								next_s.value = next_s.startVal;
								next_s.backLeg = 1'b0;
							end
						end
					end
				end
				SWSEQ_HOLD:
				begin
					if (cmdWord[`SWSEQ_CMD_RESUME])
					begin
						next_s.phase = SWSEQ_RUN;
					end
				end
				SWSEQ_DRAIN:
				begin
					// Oscillation keeps going past the sweep time until the chosen boundary
					if (boundary)
					begin
						next_s.osc = 1'b0;
						if (shuttle && !s.backLeg)
						begin
							next_s.phase = SWSEQ_WAIT;
							next_s.backLeg = 1'b1;
						end
						else
						begin
							next_s.phase = SWSEQ_IDLE;
							next_s.value = next_s.startVal;
							next_s.backLeg = 1'b0;
						end
					end
				end
				default: ;
			endcase
		end

		// Address phase: capture and preload read data from the updated copy
		next_s.busWr = 1'b0;
		if (hsel && hready && htrans[1])
		begin
			next_s.busWr = hwrite && (hsize == 3'b010);
			next_s.busAddr = haddr[7:0];
			case (haddr[7:0])
				`SWSEQ_OFF_CTRL: next_s.rdata = {21'h00_0000, next_s.ctrl};
				`SWSEQ_OFF_START: next_s.rdata = {16'h0000, next_s.startVal};
				`SWSEQ_OFF_END: next_s.rdata = {16'h0000, next_s.endVal};
				`SWSEQ_OFF_TIME: next_s.rdata = next_s.sweepTime;
				`SWSEQ_OFF_PERIOD: next_s.rdata = next_s.trigPeriod;
				`SWSEQ_OFF_IDLE: next_s.rdata = {25'h000_0000, next_s.idleLevel};
				`SWSEQ_OFF_STATUS: next_s.rdata = {24'h00_0000, next_s.backLeg, next_s.sync, next_s.osc,
					next_s.trigd, conflict, next_s.phase};
				`SWSEQ_OFF_VALUE: next_s.rdata = {16'h0000, next_s.value};
				`SWSEQ_OFF_PHASE: next_s.rdata = {16'h0000, next_s.phaseReg};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			s <= '0;
			s.ctrl <= `SWSEQ_RST_CTRL;
			s.startVal <= `SWSEQ_RST_START;
			s.endVal <= `SWSEQ_RST_END;
			s.sweepTime <= `SWSEQ_RST_TIME;
			s.trigPeriod <= `SWSEQ_RST_PERIOD;
			s.idleLevel <= `SWSEQ_RST_IDLE;
			s.phaseReg <= `SWSEQ_RST_PHASE;
			s.value <= `SWSEQ_RST_START;
			s.sync <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Zero-wait slave; unmapped reads return zero, unmapped writes are dropped
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;

	assign gen.value = s.value;
	assign gen.oscEnable = s.osc;
	assign gen.haltUseLevel = idleEn;
	assign gen.haltLevel = s.idleLevel;
	assign gen.startPhase = isPhase ? s.startVal : s.phaseReg;
	assign gen.stopPhase = isPhase ? s.endVal : s.phaseReg;
	assign sweepSyncOut = syncEn ? s.sync : 1'b0;
	assign trigAccepted = s.trigPulse;
endmodule

//--- hw/swseq_defines.svh
// Register offsets, field positions, reset values and command bits of the sweep sequencer
`ifndef SWSEQ_DEFINES_SVH
`define SWSEQ_DEFINES_SVH

`define SWSEQ_OFF_CTRL 8'h00
`define SWSEQ_OFF_START 8'h04
`define SWSEQ_OFF_END 8'h08
`define SWSEQ_OFF_TIME 8'h0C
`define SWSEQ_OFF_PERIOD 8'h10
`define SWSEQ_OFF_IDLE 8'h14
`define SWSEQ_OFF_CMD 8'h18
`define SWSEQ_OFF_STATUS 8'h1C
`define SWSEQ_OFF_VALUE 8'h20
`define SWSEQ_OFF_PHASE 8'h24

`define SWSEQ_CTRL_RUN 0
`define SWSEQ_CTRL_SHUTTLE 2
`define SWSEQ_CTRL_EXT 3
`define SWSEQ_CTRL_POL 4
`define SWSEQ_CTRL_IDLEEN 6
`define SWSEQ_CTRL_HALF 7
`define SWSEQ_CTRL_SYNCEN 8
`define SWSEQ_CTRL_ENABLE 9
`define SWSEQ_CTRL_ISPHASE 10

`define SWSEQ_POL_OFF 2'h0
`define SWSEQ_POL_RISE 2'h1
`define SWSEQ_POL_FALL 2'h2

`define SWSEQ_CMD_START 0
`define SWSEQ_CMD_STOP 1
`define SWSEQ_CMD_HOLD 2
`define SWSEQ_CMD_RESUME 3
`define SWSEQ_CMD_SWAP 4
`define SWSEQ_CMD_MANUAL 5
`define SWSEQ_CMD_REMOTE 6
`define SWSEQ_CMD_TOSTART 7
`define SWSEQ_CMD_TOEND 8
`define SWSEQ_CMD_CLRTRIG 9

`define SWSEQ_RST_CTRL 11'h000
`define SWSEQ_RST_START 16'h0000
`define SWSEQ_RST_END 16'h0100
`define SWSEQ_RST_TIME 32'h0000_0100
`define SWSEQ_RST_PERIOD 32'h0003_0D40
`define SWSEQ_RST_IDLE 7'h00
`define SWSEQ_RST_PHASE 16'h0000
`define SWSEQ_IDLE_MAX 7'h64

`endif

//--- hw/swseq_pkg.sv
// Types shared by the sweep sequencer modules
package swseq_pkg;

	typedef enum logic [2:0] {
		SWSEQ_IDLE = 3'b000,
		SWSEQ_RUN = 3'b001,
		SWSEQ_HOLD = 3'b010,
		SWSEQ_WAIT = 3'b011,
		SWSEQ_DRAIN = 3'b100,
		SWSEQ_FORCE = 3'b101
	} swseq_phase_t;

	typedef enum logic [1:0] {
		SWSEQ_CONT = 2'b00,
		SWSEQ_SINGLE = 2'b01,
		SWSEQ_GATED = 2'b10
	} swseq_run_t;

	typedef struct packed {
		logic [15:0] value;
		logic oscEnable;
		logic haltUseLevel;
		logic [6:0] haltLevel;
		logic [15:0] startPhase;
		logic [15:0] stopPhase;
	} swseq_gen_t;

	typedef struct packed {
		logic [10:0] ctrl;
		logic [15:0] startVal;
		logic [15:0] endVal;
		logic [31:0] sweepTime;
		logic [31:0] trigPeriod;
		logic [6:0] idleLevel;
		logic [15:0] phaseReg;
		swseq_phase_t phase;
		logic [15:0] value;
		logic [31:0] err;
		logic [31:0] elapsed;
		logic backLeg;
		logic stopped;
		logic osc;
		logic sync;
		logic trigd;
		logic trigPulse;
		logic pinMeta;
		logic pinSync;
		logic pinPrev;
		logic busWr;
		logic [7:0] busAddr;
		logic [31:0] rdata;
	} swseq_state_t;

	typedef struct packed {
		logic [31:0] count;
	} swseq_timer_t;

endpackage

//--- hw/swseq_trig_timer.sv
// Internal trigger timer: one tick per programmed period
`timescale 1ns/1ps
module swseq_trig_timer
	import swseq_pkg::*;
(
	input wire logic clk,
	input wire logic rstN,
	input wire logic run,
	input wire logic [31:0] period,
	output logic tick
);
	swseq_timer_t s;
	swseq_timer_t next_s;

	// Period counted in clk cycles; zero period is blocked as a conflict upstream
	assign tick = run && (s.count == period - 32'h0000_0001);

	always_comb
	begin
		next_s = s;
		if (!run || tick)
		begin
			next_s.count = 32'h0000_0000;
		end
		else
		begin
			next_s.count = s.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end
endmodule

//--- tb/swseq_top_properties.sv
// Port assertions for the sweep sequencer, bound into its top
`timescale 1ns/1ps
`include "swseq_defines.svh"
module swseq_checker
	import swseq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic cycleEdge,
	input wire logic halfCycleEdge,
	input wire swseq_gen_t gen,
	input wire logic trigAccepted,
	input wire logic conflict
);
	logic dp;
	logic dw;
	logic [7:0] da;
	wire logic wr = dp & dw;
	wire logic rd = dp & ~dw;
	wire logic bnd = cycleEdge | halfCycleEdge;
	// Data-phase tracker: a bus write is the only lawful cause of a setup change
	always_ff @(posedge clk)
	begin
		dp <= hsel & hready & htrans[1];
		dw <= hwrite;
		da <= haddr[7:0];
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence pulse_s;
		trigAccepted ##1 !trigAccepted;
	endsequence
	sequence conflict_s;
		conflict [*2];
	endsequence
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait OKAY");
	cmd_read_a: assert property (rd && da == `SWSEQ_OFF_CMD |-> hrdata == 32'h0)
		else $error("command register read not zero");
	trig_pulse_a: assert property (trigAccepted |-> pulse_s)
		else $error("trigger indication longer than one cycle");
	conflict_block_a: assert property (conflict_s |-> !trigAccepted)
		else $error("trigger taken during conflict");
	conflict_start_a: assert property (conflict [*3] |-> !$rose(gen.oscEnable))
		else $error("oscillation started during conflict");
	osc_halt_a: assert property ($fell(gen.oscEnable) |-> $past(bnd) || $past(bnd, 2) || $past(wr))
		else $error("oscillation halted off a cycle boundary");
	idle_cfg_a: assert property ($changed(gen.haltLevel) || $changed(gen.haltUseLevel) |-> $past(wr))
		else $error("idle level changed without a write");
	phase_cfg_a: assert property ($changed(gen.startPhase) || $changed(gen.stopPhase) |-> $past(wr))
		else $error("oscillation phase changed without a write");
endmodule
bind swseq_top swseq_checker chk_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.hrdata, .cycleEdge, .halfCycleEdge, .gen, .trigAccepted, .conflict);

//--- tb/swseq_far_end.sv
// Far-side model: waveform cycle boundaries and the external trigger pin
`timescale 1ns/1ps
module swseq_far_end
(
	input wire logic clk,
	input wire logic fire,
	output logic trigIn,
	output logic cycleEdge,
	output logic halfCycleEdge
);
	logic [2:0] ph = 3'h0;
	logic [2:0] hi = 3'h0;
	always @(posedge clk)
	begin
		ph <= ph + 3'h1;
		hi <= fire ? 3'h4 : hi - 3'(hi != 3'h0);
	end
	// Four clocks per level, above the two the pin sampler needs
	assign trigIn = hi != 3'h0;
	assign cycleEdge = ph == 3'h7;
	assign halfCycleEdge = ph[1:0] == 2'h3;
endmodule

//--- tb/test_sweep_sequencer.sv
// Self-checking bench for the sweep sequencer
`timescale 1ns/1ps
`include "swseq_defines.svh"
module test_sweep_sequencer
	import swseq_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic fire = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, trigIn, cycleEdge, halfCycleEdge, sweepSyncOut, trigAccepted, conflict;
	logic [31:0] hrdata, q;
	swseq_gen_t gen;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	logic [103:0] rows [10];
	always #2.5 clk = ~clk;
	swseq_top dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .trigIn, .cycleEdge, .halfCycleEdge, .gen, .sweepSyncOut, .trigAccepted, .conflict);
	swseq_far_end far_u (.clk, .fire, .trigIn, .cycleEdge, .halfCycleEdge);
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic waitv(input logic [15:0] v, input int k);
		repeat (k) if (gen.value !== v) @(posedge clk);
		chk(32'(gen.value), 32'(v));
	endtask
	task automatic pulse(input int k);
		repeat (k) if (trigAccepted !== 1'b1) @(posedge clk);
		chk(32'(trigAccepted), 32'h1);
	endtask
	// Ceiling several times the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fail_count++;
			finish_test();
		end
	end
	initial
	begin
		rows = '{{`SWSEQ_OFF_START, 32'h0, 32'hFFFF_0010, 32'h10}, {`SWSEQ_OFF_END, 32'h100, 32'h18, 32'h18},
			{`SWSEQ_OFF_TIME, 32'h100, 32'h8, 32'h8}, {`SWSEQ_OFF_PERIOD, 32'h30D40, 32'h14, 32'h14},
			{`SWSEQ_OFF_IDLE, 32'h0, 32'hB2, 32'h32}, {`SWSEQ_OFF_PHASE, 32'h0, 32'h1234_5678, 32'h5678},
			{`SWSEQ_OFF_CMD, 32'h0, 32'h0, 32'h0}, {`SWSEQ_OFF_STATUS, 32'h40, 32'hFF, 32'h40},
			{`SWSEQ_OFF_VALUE, 32'h10, 32'hFF, 32'h10}, {8'h40, 32'h0, 32'hFFFF_FFFF, 32'h0}};
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk({28'h0, sweepSyncOut, trigAccepted, conflict, gen.oscEnable}, 32'h0);
		foreach (rows[i])
		begin
			rdc(rows[i][103:96], rows[i][95:64]);
			wr(rows[i][103:96], rows[i][63:32]);
			rdc(rows[i][103:96], rows[i][31:0]);
		end
		wr(`SWSEQ_OFF_CTRL, 32'h300);
		// One-way legs wrap to start on the edge that would show the end value
		waitv(16'h17, 20);
		chk(32'(sweepSyncOut), 32'h1);
		waitv(16'h10, 2);
		repeat (2) @(posedge clk);
		chk(32'(sweepSyncOut), 32'h0);
		wr(`SWSEQ_OFF_CMD, 32'h10);
		rdc(`SWSEQ_OFF_START, 32'h18);
		waitv(16'h11, 20);
		waitv(16'h18, 2);
		wr(`SWSEQ_OFF_CMD, 32'h10);
		wr(`SWSEQ_OFF_CMD, 32'h2);
		repeat (10) @(posedge clk);
		chk(32'(gen.value), 32'h10);
		wr(`SWSEQ_OFF_CMD, 32'h1);
		waitv(16'h17, 12);
		repeat (3) @(posedge clk);
		wr(`SWSEQ_OFF_CMD, 32'h4);
		q = 32'(gen.value);
		repeat (6) @(posedge clk);
		chk(32'(gen.value), q);
		wr(`SWSEQ_OFF_CMD, 32'h8);
		waitv(16'h17, 12);
		wr(`SWSEQ_OFF_CTRL, 32'h304);
		waitv(16'h18, 24);
		n = 0;
		while (gen.value !== 16'h10 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), 32'h8);
		wr(`SWSEQ_OFF_CTRL, 32'h0);
		wr(`SWSEQ_OFF_CTRL, 32'h209);
		repeat (20) @(posedge clk);
		chk(32'(gen.value), 32'h10);
		for (int i = 0; i < 2; i++)
		begin
			wr(`SWSEQ_OFF_CMD, 32'h20 << i);
			pulse(4);
			waitv(16'h17, 12);
			@(posedge clk);
			chk(32'(gen.value), 32'h10);
		end
		wr(`SWSEQ_OFF_TIME, 32'h4);
		@(posedge clk);
		chk(32'(conflict), 32'h1);
		wr(`SWSEQ_OFF_CMD, 32'h20);
		repeat (12) @(posedge clk);
		chk(32'(gen.value), 32'h10);
		wr(`SWSEQ_OFF_TIME, 32'h8);
		@(posedge clk);
		chk(32'(conflict), 32'h0);
		for (int i = 1; i < 3; i++)
		begin
			wr(`SWSEQ_OFF_CTRL, 32'h209 | (32'(i) << 4));
			fire <= 1'b1;
			@(posedge clk);
			fire <= 1'b0;
			pulse(16);
			waitv(16'h17, 12);
		end
		wr(`SWSEQ_OFF_CTRL, 32'h20D);
		wr(`SWSEQ_OFF_CMD, 32'h20);
		waitv(16'h18, 14);
		repeat (10) @(posedge clk);
		chk(32'(gen.value), 32'h18);
		wr(`SWSEQ_OFF_CMD, 32'h20);
		wr(`SWSEQ_OFF_CMD, 32'h4);
		wr(`SWSEQ_OFF_CMD, 32'h20);
		waitv(16'h10, 3);
		for (int i = 0; i < 2; i++)
		begin
			wr(`SWSEQ_OFF_CTRL, 32'h0);
			wr(`SWSEQ_OFF_CTRL, 32'h64A | (32'(i) << 7));
			@(posedge clk);
			chk(32'({gen.haltUseLevel, gen.haltLevel, gen.oscEnable}), 32'h164);
			chk({gen.startPhase, gen.stopPhase}, 32'h0010_0018);
			wr(`SWSEQ_OFF_CMD, 32'h20);
			pulse(4);
			@(posedge clk);
			chk(32'(gen.oscEnable), 32'h1);
			repeat (30) if (gen.oscEnable === 1'b1) @(posedge clk);
			chk(32'(gen.oscEnable), 32'h0);
			// Boundary seen one clock before the halt: whole cycle at ph 7, half cycle at ph 3 or 7
			chk(32'(far_u.ph & (i == 0 ? 3'h7 : 3'h3)), 32'h0);
		end
		wr(`SWSEQ_OFF_CMD, 32'h80);
		@(posedge clk);
		chk({gen.value, 15'h0, gen.oscEnable}, 32'h0010_0001);
		wr(`SWSEQ_OFF_CMD, 32'h100);
		repeat (20) @(posedge clk);
		chk({gen.value, 15'h0, gen.oscEnable}, 32'h0018_0001);
		wr(`SWSEQ_OFF_CMD, 32'h2);
		repeat (12) if (gen.oscEnable === 1'b1) @(posedge clk);
		chk({gen.value, 15'h0, gen.oscEnable}, 32'h0010_0000);
		wr(`SWSEQ_OFF_CTRL, 32'h201);
		pulse(25);
		@(posedge clk);
		n = 0;
		while (trigAccepted !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), 32'h13);
		bus(1'b0, `SWSEQ_OFF_STATUS, 32'h0);
		chk(q & 32'h10, 32'h10);
		wr(`SWSEQ_OFF_CMD, 32'h200);
		bus(1'b0, `SWSEQ_OFF_STATUS, 32'h0);
		chk(q & 32'h10, 32'h0);
		wr(`SWSEQ_OFF_CTRL, 32'h203);
		@(posedge clk);
		chk(32'({conflict, gen.haltUseLevel}), 32'h2);
		chk({gen.startPhase, gen.stopPhase}, 32'h5678_5678);
		finish_test();
	end
endmodule
